// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cpt_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observation signals
  // ---------------------------------------------------------------
  logic        ref_clk_in;   // 125 MHz register clock
  logic        nrst_in;      // sync reset, active low
  logic [11:0] paddr;        // apb request
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;       // apb answer
  logic        pready;
  logic        pslverr;
  logic [6:0]  vout [6];     // effective values, table order
  int          error_cnt;    // mismatches seen
  int          checked;      // comparisons made
  // reset values at 800 Mbps: post, prep, zero, trail, exit, lpx
  logic [6:0]  rst_val [6] = '{7'h0a, 7'h06, 7'h0c, 7'h08, 7'h0b, 7'h06};
  logic [31:0] rd;
  logic        err;

  cpt_regs u_dut (
    .ref_clk_in             (ref_clk_in),
    .nrst_in                (nrst_in),
    .paddr_in               (paddr),
    .psel_in                (psel),
    .penable_in             (penable),
    .pwrite_in              (pwrite),
    .pwdata_in              (pwdata),
    .pstrb_in               (4'hf),
    .prdata_out             (prdata),
    .pready_out             (pready),
    .pslverr_out            (pslverr),
    .clock_post_value_out   (vout[0]),
    .data_prepare_value_out (vout[1]),
    .data_zero_value_out    (vout[2]),
    .data_trail_value_out   (vout[3]),
    .data_exit_value_out    (vout[4]),
    .lpx_value_out          (vout[5])
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // word index to byte address
  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t data got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= {24'h0, d};
    @(posedge ref_clk_in);
    penable <= 1'b1;
    // wait as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge ref_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  // value outputs lag the write edge by one edge; let them land
  task automatic chk_out(input int k, input logic [6:0] exp);
    repeat (2) @(posedge ref_clk_in);
    chk_data({25'h0, vout[k]}, {25'h0, exp});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_reset;
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, addr_of(IDX_CLOCK_POST + k[7:0]), 8'h00);
      chk_data(rd, {25'h0, rst_val[k]});
      chk_flag(err, 1'b0);
      chk_out(k, rst_val[k]);
    end
  endtask

  // value bits written with override clear must be dropped
  task automatic s_ro_write;
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, addr_of(IDX_CLOCK_POST + k[7:0]), 8'h55);
      apb(1'b0, addr_of(IDX_CLOCK_POST + k[7:0]), 8'h00);
      chk_data(rd, {25'h0, rst_val[k]});
      chk_out(k, rst_val[k]);
    end
  endtask

  task automatic s_override;
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, addr_of(IDX_CLOCK_POST + k[7:0]), 8'ha0 + k[7:0]);
      apb(1'b0, addr_of(IDX_CLOCK_POST + k[7:0]), 8'h00);
      chk_data(rd, {24'h0, 8'ha0 + k[7:0]});
      chk_out(k, 7'h20 + k[6:0]);
    end
  endtask

  // only the clock-post field stays overridden across a rate change
  task automatic s_rate;
    for (int k = 1; k < 6; k++)
      apb(1'b1, addr_of(IDX_CLOCK_POST + k[7:0]), 8'h00);
    apb(1'b1, addr_of(IDX_LANE_RATE), 8'h00);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, addr_of(IDX_CLOCK_POST + k[7:0]), 8'h00);
      if (k == 0) begin
        chk_data(rd, 32'ha0);
      end else begin
        chk_data(rd, {25'h0, TIMING_400[k*7 +: 7]});
        chk_out(k, TIMING_400[k*7 +: 7]);
      end
    end
    apb(1'b1, addr_of(IDX_LANE_RATE), 8'h01);
    apb(1'b0, addr_of(IDX_DATA_ZERO), 8'h00);
    chk_data(rd, {25'h0, rst_val[2]});
  endtask

  task automatic s_reserved;
    for (int i = 32'h69; i <= 32'h71; i++) begin
      apb(1'b1, addr_of(i[7:0]), 8'hff);
      apb(1'b0, addr_of(i[7:0]), 8'h00);
      chk_data(rd, 32'h0);
      chk_flag(err, 1'b0);
    end
    // unmapped and misaligned places answer with an error
    apb(1'b0, 12'hffc, 8'h00);
    chk_flag(err, 1'b1);
    apb(1'b1, addr_of(IDX_CLOCK_POST) + 12'h001, 8'h80);
    chk_flag(err, 1'b1);
    apb(1'b0, addr_of(IDX_CLOCK_POST), 8'h00);
    chk_data(rd, 32'ha0);
  endtask

  // ---------------------------------------------------------------
  // closing, clock, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    error_cnt = 0;
    checked   = 0;
    nrst_in   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    repeat (3) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(posedge ref_clk_in);
    s_reset();
    s_ro_write();
    s_override();
    s_rate();
    s_reserved();
    summarize();
  end
endmodule

// >>> verilog/cpt_pkg.sv
package cpt_pkg;
  // ---------------------------------------------------------------
  // register map (indices; byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int unsigned NUM_TIMING = 6;            // timing registers
  localparam logic [7:0]  IDX_CLOCK_POST   = 8'h63;  // first timing reg
  localparam logic [7:0]  IDX_DATA_PREPARE = 8'h64;
  localparam logic [7:0]  IDX_DATA_ZERO    = 8'h65;
  localparam logic [7:0]  IDX_DATA_TRAIL   = 8'h66;
  localparam logic [7:0]  IDX_DATA_EXIT    = 8'h67;
  localparam logic [7:0]  IDX_LPX          = 8'h68;
  localparam logic [7:0]  IDX_RSVD_FIRST   = 8'h69;  // reserved range
  localparam logic [7:0]  IDX_RSVD_LAST    = 8'h71;
  localparam logic [7:0]  IDX_LANE_RATE    = 8'h72;  // lane rate select
  localparam logic [11:0] ADDR_SHIFT_ONE   = 12'h004; // one word step

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int unsigned OVR_BIT   = 7;    // override select position
  localparam int unsigned VAL_WIDTH = 7;    // value field width

  // ---------------------------------------------------------------
  // lane rates and derived timing tables (values in bits 6:0)
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CPT_RATE_400, CPT_RATE_800, CPT_RATE_1200, CPT_RATE_1500,
    CPT_RATE_1600
  } cpt_rate_t;
  localparam logic [2:0] RATE_RESET = 3'h1;  // 800 Mbps after reset

  // order: clock_post, prepare, zero, trail, exit, lpx
  localparam logic [41:0] TIMING_800 =
    {7'h06, 7'h0b, 7'h08, 7'h0c, 7'h06, 7'h0a};
  localparam logic [41:0] TIMING_400 =
    {7'h03, 7'h06, 7'h04, 7'h06, 7'h03, 7'h05};
  localparam logic [41:0] TIMING_1200 =
    {7'h09, 7'h10, 7'h0c, 7'h12, 7'h09, 7'h0f};
  localparam logic [41:0] TIMING_1500 =
    {7'h0b, 7'h14, 7'h0f, 7'h17, 7'h0b, 7'h13};
  localparam logic [41:0] TIMING_1600 =
    {7'h0c, 7'h16, 7'h10, 7'h18, 7'h0c, 7'h14};
endpackage

// >>> verilog/cpt_regs.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module cpt_regs (
  input  wire logic        ref_clk_in,    // register clock, 125 MHz
  input  wire logic        nrst_in,       // sync reset, active low
  input  wire logic [11:0] paddr_in,      // apb byte address
  input  wire logic        psel_in,       // apb select
  input  wire logic        penable_in,    // apb access phase
  input  wire logic        pwrite_in,     // apb direction
  input  wire logic [31:0] pwdata_in,     // apb write data
  input  wire logic [3:0]  pstrb_in,      // apb byte strobes
  output logic      [31:0] prdata_out,    // apb read data
  output logic             pready_out,    // apb ready
  output logic             pslverr_out,   // apb error, unmapped
  output logic      [6:0]  clock_post_value_out,   // effective values
  output logic      [6:0]  data_prepare_value_out,
  output logic      [6:0]  data_zero_value_out,
  output logic      [6:0]  data_trail_value_out,
  output logic      [6:0]  data_exit_value_out,
  output logic      [6:0]  lpx_value_out
);
  import cpt_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [9:0]  word_idx;          // word index of the access
  logic        aligned;           // low address bits zero
  logic        setup;             // setup phase seen
  logic        hit_timing;        // index inside the timing block
  logic        hit_rsvd;          // index inside the reserved range
  logic        hit_rate;          // lane rate register
  logic [2:0]  slot;              // timing register number 0..5
  logic [2:0]  lane_rate;         // software lane rate select
  logic [41:0] auto_vec;          // derived values, all six
  logic [5:0]  ovr_vec;           // override bits, all six
  logic [41:0] val_vec;           // effective values, all six
  logic [5:0]  wr_vec;            // per-register write strobes
  logic [7:0]  read_byte;         // selected register content
  logic        wr_ok;             // write is accepted this cycle

  assign word_idx   = paddr_in[11:2];
  assign aligned    = (paddr_in[1:0] == 2'b00);
  assign setup      = psel_in && !penable_in;
  assign hit_timing = aligned && word_idx >= {2'b00, IDX_CLOCK_POST}
                      && word_idx <= {2'b00, IDX_LPX};
  assign hit_rsvd   = aligned && word_idx >= {2'b00, IDX_RSVD_FIRST}
                      && word_idx <= {2'b00, IDX_RSVD_LAST};
  assign hit_rate   = aligned && word_idx == {2'b00, IDX_LANE_RATE};
  assign slot       = 3'(word_idx[7:0] - IDX_CLOCK_POST);
  // writes land in the access phase, one cycle after setup
  assign wr_ok      = psel_in && penable_in && pready_out && pwrite_in
                      && pstrb_in[0];

  // ---------------------------------------------------------------
  // lane rate select and derived timing
  // ---------------------------------------------------------------
  // lane rate register; unknown codes fall back to 800 Mbps tables
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      lane_rate <= RATE_RESET;
    end else if (wr_ok && hit_rate) begin
      lane_rate <= pwdata_in[2:0];
    end
  end

  // derived values follow the selected rate immediately
  always_comb begin
    case (lane_rate)
      3'(CPT_RATE_400):  auto_vec = TIMING_400;
      3'(CPT_RATE_800):  auto_vec = TIMING_800;
      3'(CPT_RATE_1200): auto_vec = TIMING_1200;
      3'(CPT_RATE_1500): auto_vec = TIMING_1500;
      3'(CPT_RATE_1600): auto_vec = TIMING_1600;
      default:           auto_vec = TIMING_800;
    endcase
  end

  // ---------------------------------------------------------------
  // six timing registers, one field module each
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_TIMING; g++) begin : g_field
      assign wr_vec[g] = wr_ok && hit_timing && (slot == 3'(g));
      // each slot: bit 7 picks derived or programmed
      cpt_timing_field u_field (
        .ref_clk_in    (ref_clk_in),
        .nrst_in       (nrst_in),
        .wr_in         (wr_vec[g]),
        .wdata_in      (pwdata_in[7:0]),
        .auto_value_in (auto_vec[g*VAL_WIDTH +: VAL_WIDTH]),
        .ovr_out       (ovr_vec[g]),
        .value_out     (val_vec[g*VAL_WIDTH +: VAL_WIDTH])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // reserved and unmapped words read zero
  always_comb begin
    read_byte = 8'h00;
    if (hit_timing && slot < 3'(NUM_TIMING)) begin
      read_byte = {ovr_vec[slot], val_vec[slot*VAL_WIDTH +: VAL_WIDTH]};
    end else if (hit_rate) begin
      read_byte = {5'h00, lane_rate};
    end
  end

  // ---------------------------------------------------------------
  // apb slave: no wait state, ready registered from the setup
  // ---------------------------------------------------------------
  // pready rises in the first access cycle and drops after it
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= setup;
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      prdata_out  <= pwrite_in ? 32'h0000_0000 : {24'h00_0000, read_byte};
      pslverr_out <= !(hit_timing || hit_rsvd || hit_rate);
    end else begin
      pslverr_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // effective timing outputs, registered
  // ---------------------------------------------------------------
  // registering costs one cycle of lag to the phy, which is harmless
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      clock_post_value_out   <= TIMING_800[6:0];
      data_prepare_value_out <= TIMING_800[13:7];
      data_zero_value_out    <= TIMING_800[20:14];
      data_trail_value_out   <= TIMING_800[27:21];
      data_exit_value_out    <= TIMING_800[34:28];
      lpx_value_out          <= TIMING_800[41:35];
    end else begin
      clock_post_value_out   <= val_vec[6:0];
      data_prepare_value_out <= val_vec[13:7];
      data_zero_value_out    <= val_vec[20:14];
      data_trail_value_out   <= val_vec[27:21];
      data_exit_value_out    <= val_vec[34:28];
      lpx_value_out          <= val_vec[41:35];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_setup_read;
    psel_in && !penable_in && !pwrite_in;
  endsequence

  property p_ready_after_setup;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      psel_in && !penable_in |=> pready_out;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("pready did not follow setup");

  property p_post_src;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !ovr_vec[0] |=> clock_post_value_out == $past(auto_vec[6:0]);
  endproperty
  a_post_src: assert property (p_post_src)
    else $error("clock post not derived while override clear");

  property p_prep_src;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !ovr_vec[1] |=> data_prepare_value_out == $past(auto_vec[13:7]);
  endproperty
  a_prep_src: assert property (p_prep_src)
    else $error("prepare not derived while override clear");

  property p_zero_src;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !ovr_vec[2] |=> data_zero_value_out == $past(auto_vec[20:14]);
  endproperty
  a_zero_src: assert property (p_zero_src)
    else $error("zero not derived while override clear");

  property p_trail_src;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !ovr_vec[3] |=> data_trail_value_out == $past(auto_vec[27:21]);
  endproperty
  a_trail_src: assert property (p_trail_src)
    else $error("trail not derived while override clear");

  property p_exit_src;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !ovr_vec[4] |=> data_exit_value_out == $past(auto_vec[34:28]);
  endproperty
  a_exit_src: assert property (p_exit_src)
    else $error("exit not derived while override clear");

  property p_lpx_src;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !ovr_vec[5] |=> lpx_value_out == $past(auto_vec[41:35]);
  endproperty
  a_lpx_src: assert property (p_lpx_src)
    else $error("lpx not derived while override clear");

  property p_override_write;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_vec[0] && pwdata_in[7] |=> ##1
        clock_post_value_out == $past(pwdata_in[6:0], 2);
  endproperty
  a_override_write: assert property (p_override_write)
    else $error("programmed clock post not applied");

  property p_rsvd_zero;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      s_setup_read ##0 hit_rsvd |=> prdata_out == 32'h0000_0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved word read nonzero");

  property p_readback_auto;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      s_setup_read ##0 (hit_timing && !ovr_vec[slot]) |=>
        prdata_out[6:0] == $past(auto_vec[slot*VAL_WIDTH +: VAL_WIDTH]);
  endproperty
  a_readback_auto: assert property (p_readback_auto)
    else $error("read of clear field not the derived value");

  property p_ignore_write;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_vec[0] && !pwdata_in[7] |=> ##1
        clock_post_value_out == $past(auto_vec[6:0]);
  endproperty
  a_ignore_write: assert property (p_ignore_write)
    else $error("write with override clear changed clock post");

  property p_rate_reset;
    @(posedge ref_clk_in) $rose(nrst_in) |-> lane_rate == RATE_RESET;
  endproperty
  a_rate_reset: assert property (p_rate_reset)
    else $error("lane rate not 800 after reset");

  // a write that sets override: value taken at the write edge, then
  // the output register copies it one edge later
  property p_prep_override;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_vec[1] && pwdata_in[7] |=> ##1
        data_prepare_value_out == $past(pwdata_in[6:0], 2);
  endproperty
  a_prep_override: assert property (p_prep_override)
    else $error("programmed prepare value not applied");

  property p_zero_override;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_vec[2] && pwdata_in[7] |=> ##1
        data_zero_value_out == $past(pwdata_in[6:0], 2);
  endproperty
  a_zero_override: assert property (p_zero_override)
    else $error("programmed zero value not applied");

  property p_trail_override;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_vec[3] && pwdata_in[7] |=> ##1
        data_trail_value_out == $past(pwdata_in[6:0], 2);
  endproperty
  a_trail_override: assert property (p_trail_override)
    else $error("programmed trail value not applied");

  property p_exit_override;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_vec[4] && pwdata_in[7] |=> ##1
        data_exit_value_out == $past(pwdata_in[6:0], 2);
  endproperty
  a_exit_override: assert property (p_exit_override)
    else $error("programmed exit value not applied");

  property p_lpx_override;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_vec[5] && pwdata_in[7] |=> ##1
        lpx_value_out == $past(pwdata_in[6:0], 2);
  endproperty
  a_lpx_override: assert property (p_lpx_override)
    else $error("programmed lpx value not applied");

  // ready is a single pulse; a stuck ready would complete ghost writes
  property p_ready_pulse;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      pready_out |=> !pready_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held longer than one cycle");

  // the error flag only qualifies a completing transfer
  property p_err_with_ready;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      pslverr_out |-> pready_out;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr raised without pready");

  // reserved words are mapped: no error for either direction
  property p_rsvd_no_err;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      psel_in && !penable_in && hit_rsvd |=> !pslverr_out;
  endproperty
  a_rsvd_no_err: assert property (p_rsvd_no_err)
    else $error("reserved word answered with an error");

  // a write into the reserved range must leave all state alone
  property p_rsvd_inert;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_ok && hit_rsvd |=> $stable(ovr_vec) && $stable(lane_rate);
  endproperty
  a_rsvd_inert: assert property (p_rsvd_inert)
    else $error("reserved write changed register state");

  // an overridden field reads back with its select bit set
  property p_readback_ovr;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      s_setup_read ##0 (hit_timing && ovr_vec[slot]) |=> prdata_out[7];
  endproperty
  a_readback_ovr: assert property (p_readback_ovr)
    else $error("override bit not read back as set");

  // a rate write lands at its access edge
  property p_rate_follow;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_ok && hit_rate |=> lane_rate == $past(pwdata_in[2:0]);
  endproperty
  a_rate_follow: assert property (p_rate_follow)
    else $error("lane rate write not taken");

  // outputs come out of reset at the 800 Mbps table
  property p_values_reset;
    @(posedge ref_clk_in)
      !nrst_in |=> {lpx_value_out, data_exit_value_out,
        data_trail_value_out, data_zero_value_out,
        data_prepare_value_out, clock_post_value_out} == TIMING_800;
  endproperty
  a_values_reset: assert property (p_values_reset)
    else $error("timing outputs not at 800 Mbps defaults");
endmodule

// >>> verilog/cpt_timing_field.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// one override-capable timing field: select bit plus 7-bit value
// ---------------------------------------------------------------
module cpt_timing_field (
  input  wire logic       ref_clk_in,     // register clock
  input  wire logic       nrst_in,        // sync reset, active low
  input  wire logic       wr_in,          // write strobe for this reg
  input  wire logic [7:0] wdata_in,       // write byte
  input  wire logic [6:0] auto_value_in,  // derived value
  output logic            ovr_out,        // override select
  output logic      [6:0] value_out       // effective value
);
  import cpt_pkg::*;

  logic [6:0] prog_value;  // programmed value, held while selected

  // override select bit, plain read/write
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      ovr_out <= 1'b0;
    end else if (wr_in) begin
      ovr_out <= wdata_in[OVR_BIT];
    end
  end

  // the value is only taken when the same write leaves override set;
  // the value bits of a write with override clear are dropped
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      prog_value <= 7'h00;
    end else if (wr_in && wdata_in[OVR_BIT]) begin
      prog_value <= wdata_in[6:0];
    end else if (!ovr_out) begin
      // track derived value so switching on override is glitch free
      prog_value <= auto_value_in;
    end
  end

  // effective value: derived when clear, programmed when set
  always_comb begin
    value_out = ovr_out ? prog_value : auto_value_in;
  end
endmodule
